// ### logic/cssel_map.svh
`ifndef CSSEL_MAP_SVH
`define CSSEL_MAP_SVH

// clock source select fuse codes
`define CSSEL_CK_EXT_CLK    4'h0
`define CSSEL_CK_INT_LO     4'h1
`define CSSEL_CK_INT_HI     4'h4
`define CSSEL_CK_ERC_LO     4'h5
`define CSSEL_CK_ERC_HI     4'h8

// factory fuse state
`define CSSEL_CK_FACTORY    4'h1
`define CSSEL_SUT_FACTORY   2'h2

// start-up time select codes
`define CSSEL_SUT_NONE      2'h0
`define CSSEL_SUT_SHORT     2'h1
`define CSSEL_SUT_LONG      2'h2
`define CSSEL_SUT_ALT       2'h3

// start-up cycles of the selected source
`define CSSEL_SU_LONG_CK    17'h00012
`define CSSEL_SU_SHORT_CK   17'h00006

// short reset delay in watchdog cycles (about 4.1 ms)
`define CSSEL_DLY_SHORT_CYC 17'h01000

// signature row location of the 1 MHz calibration byte
`define CSSEL_SIGROW_CAL    8'h00

// register byte offsets
`define CSSEL_OFS_TRIM      12'h000
`define CSSEL_OFS_STATUS    12'h004

// trim to frequency span, percent of nominal
`define CSSEL_PCT_MIN_BASE  8'h32
`define CSSEL_PCT_MIN_SPAN  16'h0032
`define CSSEL_PCT_MAX_BASE  8'h64
`define CSSEL_PCT_MAX_SPAN  16'h0064
`define CSSEL_PCT_FULL      16'h00ff
`define CSSEL_PCT_ROUND     16'h007f

`endif

// ### logic/cssel_pkg.sv
package cssel_pkg;

   typedef enum logic [3:0] {
      ST_RDLY  = 4'b0001,
      ST_START = 4'b0010,
      ST_RUN   = 4'b0100,
      ST_SLEEP = 4'b1000
   } cssel_state_t;

   typedef enum logic [2:0] {
      SRC_INT_RC  = 3'b001,
      SRC_EXT_RC  = 3'b010,
      SRC_EXT_CLK = 3'b100
   } cssel_src_t;

   typedef struct packed {
      cssel_src_t src;
      logic [1:0] range;
      logic       fuse_err;
      logic       oscillator_option_fuse_warn;
   } cssel_cfg_t;

   typedef struct packed {
      logic [10:0]  zero;
      logic [7:0]   trim;
      logic [1:0]   startup_time_select_fuses;
      logic [3:0]   clock_source_select_fuses;
      cssel_cfg_t   cfg;
   } cssel_status_t;

endpackage

// ### logic/cssel_tick_div.sv
`timescale 1ns/1ps
module cssel_tick_div
   import cssel_pkg::*;
#(
   parameter int DIV = 40
)(
   input  wire logic core_clk_i,
   input  wire logic reset_i,
   output logic      tick_o
);
   localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } cssel_div_t;

   cssel_div_t r_q;
   cssel_div_t r_d;

   always_comb
   begin
      r_d = r_q;
      r_d.tick = 1'b0;
      if (reset_i)
      begin
         r_d = '0;
      end
      else if (r_q.cnt == CW'(DIV - 1))
      begin
         r_d.cnt  = '0;
         r_d.tick = 1'b1;
      end
      else
      begin
         r_d.cnt = r_q.cnt + CW'(1);
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      r_q <= r_d;
   end

   assign tick_o = r_q.tick;
endmodule // cssel_tick_div

// ### logic/cssel_top.sv
// Operation
// - fuses 0101-1000 pick external RC ranges
// - external RC: 18 or 6 start-up cycles
// - fuses 0001-0100 pick internal RC 1-8 MHz
// - internal RC: 6 cycles, 11 reserved
// - reset loads 1 MHz calibration into trim
// - trim raises frequency monotonically, zero lowest
// - trim spans 50-100 to 100-200 percent
// - watchdog oscillator still times reset delay
// - fuses 0000 pick external clock input
// - external clock: 6 cycles, 11 reserved
// - factory fuses 0001 and 10
// - delays count 0, 4096 or 65536 watchdog cycles
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "cssel_map.svh"
module cssel_top #(
   parameter int WDT_DIV      = 40,
   parameter int DLY_LONG_CYC = 65536
)(
   input  wire logic                core_clk_i,
   input  wire logic                reset_i,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic [3:0]          clock_source_select_fuses_i,
   input  wire logic [1:0]          startup_time_select_fuses_i,
   input  wire logic                oscillator_option_fuse_i,
   input  wire logic                fuses_blank_i,
   input  wire logic [7:0]          sigrow_data_i,
   input  wire logic                src_cycle_i,
   input  wire logic                sleep_req_i,
   input  wire logic                wake_i,
   output logic      [7:0]          sigrow_addr_o,
   output cssel_pkg::cssel_cfg_t    clk_cfg_o,
   output logic      [7:0]          trim_value_o,
   output logic      [7:0]          freq_min_pct_o,
   output logic      [7:0]          freq_max_pct_o,
   output logic                     core_clk_en_o,
   output logic                     reset_hold_o,
   output logic                     wdog_tick_o
);
   import cssel_pkg::*;

   typedef struct packed {
      cssel_state_t st;
      logic [16:0]  cnt;
      logic         boot;
      logic [3:0]   clock_source_select_fuses;
      logic [1:0]   startup_time_select_fuses;
      logic         oscillator_option_fuse;
      logic [7:0]   trim;
      cssel_cfg_t   cfg;
      logic [7:0]   pct_min;
      logic [7:0]   pct_max;
      logic         core_en;
      logic         rst_hold;
      logic         wr_pend;
      logic [11:0]  wr_addr;
      logic [31:0]  rd_data;
      logic         ready;
      logic [7:0]   sig_addr;
   } cssel_regs_t;

   localparam logic [16:0] DLY_LONG = 17'(DLY_LONG_CYC);

   cssel_regs_t   r_q;
   cssel_regs_t   r_d;
   logic          wdog_tick;
   cssel_cfg_t    cfg;
   logic [16:0]   su_cycles;
   logic [16:0]   dly_cycles;
   logic [7:0]    trim_now;
   logic [15:0]   pct_lo;
   logic [15:0]   pct_hi;
   logic          take;
   cssel_status_t status;

   // the watchdog oscillator is free running and independent of the source
   cssel_tick_div #(
      .DIV        (WDT_DIV)
   ) u_wdog (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .tick_o     (wdog_tick)
   );

   // source decode from the fuse image latched at reset
   always_comb
   begin
      cfg = '0;
      cfg.src = SRC_INT_RC;
      if (r_q.clock_source_select_fuses == `CSSEL_CK_EXT_CLK)
      begin
         cfg.src = SRC_EXT_CLK;
      end
      else if (r_q.clock_source_select_fuses >= `CSSEL_CK_INT_LO && r_q.clock_source_select_fuses <= `CSSEL_CK_INT_HI)
      begin
         cfg.src   = SRC_INT_RC;
         cfg.range = 2'(r_q.clock_source_select_fuses - `CSSEL_CK_INT_LO);
      end
      else if (r_q.clock_source_select_fuses >= `CSSEL_CK_ERC_LO && r_q.clock_source_select_fuses <= `CSSEL_CK_ERC_HI)
      begin
         cfg.src   = SRC_EXT_RC;
         cfg.range = 2'(r_q.clock_source_select_fuses - `CSSEL_CK_ERC_LO);
      end
      else
      begin
         // crystal codes are not built here; fall back to the 1 MHz internal RC
         cfg.fuse_err = 1'b1;
      end
      // an option fuse programmed with the internal RC is flagged only
      cfg.oscillator_option_fuse_warn = (cfg.src == SRC_INT_RC) && r_q.oscillator_option_fuse;

      su_cycles = `CSSEL_SU_SHORT_CK;
      if (cfg.src == SRC_EXT_RC && r_q.startup_time_select_fuses != `CSSEL_SUT_ALT)
      begin
         su_cycles = `CSSEL_SU_LONG_CK;
      end

      dly_cycles = '0;
      unique case (r_q.startup_time_select_fuses)
         `CSSEL_SUT_NONE:  dly_cycles = '0;
         `CSSEL_SUT_SHORT: dly_cycles = `CSSEL_DLY_SHORT_CYC;
         `CSSEL_SUT_LONG:  dly_cycles = DLY_LONG;
         `CSSEL_SUT_ALT:
         begin
            if (cfg.src == SRC_EXT_RC)
            begin
               dly_cycles = `CSSEL_DLY_SHORT_CYC;
            end
            else
            begin
               // reserved code: take the longest delay and flag it
               dly_cycles   = DLY_LONG;
               cfg.fuse_err = 1'b1;
            end
         end
      endcase
   end

   // a read right behind a trim write sees the new value
   always_comb
   begin
      trim_now = r_q.trim;
      if (r_q.wr_pend && r_q.wr_addr == `CSSEL_OFS_TRIM)
      begin
         trim_now = hwdata[7:0];
      end
   end

   always_comb
   begin
      status       = '0;
      status.cfg   = r_q.cfg;
      status.clock_source_select_fuses = r_q.clock_source_select_fuses;
      status.startup_time_select_fuses   = r_q.startup_time_select_fuses;
      status.trim  = trim_now;
   end

   assign take = hsel && htrans[1] && hready;

   always_comb
   begin
      r_d          = r_q;
      r_d.cfg      = cfg;
      r_d.ready    = 1'b1;
      r_d.wr_pend  = 1'b0;
      r_d.rd_data  = '0;
      r_d.sig_addr = `CSSEL_SIGROW_CAL;

      // bus data phase, then address phase
      if (r_q.wr_pend && r_q.wr_addr == `CSSEL_OFS_TRIM)
      begin
         r_d.trim = hwdata[7:0];
      end
      if (take)
      begin
         r_d.wr_pend = hwrite;
         r_d.wr_addr = haddr[11:0];
         if (!hwrite)
         begin
            unique case (haddr[11:0])
               `CSSEL_OFS_TRIM:   r_d.rd_data = {24'h000000, trim_now};
               `CSSEL_OFS_STATUS: r_d.rd_data = status;
               default:           r_d.rd_data = '0;
            endcase
         end
      end

      unique case (r_q.st)
         ST_RDLY:
         begin
            // counted on the watchdog tick whatever source runs the core
            if (r_q.cnt >= dly_cycles)
            begin
               r_d.st  = ST_START;
               r_d.cnt = '0;
            end
            else if (wdog_tick)
            begin
               r_d.cnt = r_q.cnt + 17'h00001;
            end
         end
         ST_START:
         begin
            if (r_q.cnt >= su_cycles)
            begin
               r_d.st   = ST_RUN;
               r_d.cnt  = '0;
               r_d.boot = 1'b0;
            end
            else if (src_cycle_i)
            begin
               r_d.cnt = r_q.cnt + 17'h00001;
            end
         end
         ST_RUN:
         begin
            if (sleep_req_i)
            begin
               r_d.st = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (wake_i)
            begin
               r_d.st  = ST_START;
               r_d.cnt = '0;
            end
         end
      endcase

      if (reset_i)
      begin
         r_d          = '0;
         r_d.st       = ST_RDLY;
         r_d.boot     = 1'b1;
         r_d.ready    = 1'b1;
         r_d.sig_addr = `CSSEL_SIGROW_CAL;
         r_d.cfg.src  = SRC_INT_RC;
         r_d.trim     = sigrow_data_i;
         // fuses are caught while reset is held, a blank part reads factory state
         if (fuses_blank_i)
         begin
            r_d.clock_source_select_fuses = `CSSEL_CK_FACTORY;
            r_d.startup_time_select_fuses   = `CSSEL_SUT_FACTORY;
         end
         else
         begin
            r_d.clock_source_select_fuses = clock_source_select_fuses_i;
            r_d.startup_time_select_fuses   = startup_time_select_fuses_i;
         end
         r_d.oscillator_option_fuse = oscillator_option_fuse_i;
      end

      // rounded linear span keeps every step non-decreasing
      pct_lo = 16'(r_d.trim * `CSSEL_PCT_MIN_SPAN) + `CSSEL_PCT_ROUND;
      pct_hi = 16'(r_d.trim * `CSSEL_PCT_MAX_SPAN) + `CSSEL_PCT_ROUND;
      r_d.pct_min = `CSSEL_PCT_MIN_BASE + 8'(pct_lo / `CSSEL_PCT_FULL);
      r_d.pct_max = `CSSEL_PCT_MAX_BASE + 8'(pct_hi / `CSSEL_PCT_FULL);

      r_d.core_en  = (r_d.st == ST_RUN) && !reset_i;
      r_d.rst_hold = r_d.boot;
   end

   always_ff @(posedge core_clk_i)
   begin
      r_q <= r_d;
   end

   assign hrdata         = r_q.rd_data;
   assign hreadyout      = r_q.ready;
   assign hresp          = 1'b0;
   assign sigrow_addr_o  = r_q.sig_addr;
   assign clk_cfg_o      = r_q.cfg;
   assign trim_value_o   = r_q.trim;
   assign freq_min_pct_o = r_q.pct_min;
   assign freq_max_pct_o = r_q.pct_max;
   assign core_clk_en_o  = r_q.core_en;
   assign reset_hold_o   = r_q.rst_hold;
   assign wdog_tick_o    = wdog_tick;
endmodule // cssel_top

// ### verification/cssel_src_model.sv
`timescale 1ns/1ps
module cssel_src_model #(
   parameter int PER = 4
)(
   input  wire logic core_clk_i,
   output logic      src_cycle_o = 1'b0
);
   int cnt_q = 0;
   // a fixed period never steps the frequency between cycles
   always @(posedge core_clk_i)
   begin
      cnt_q       <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
      src_cycle_o <= (cnt_q == PER - 1);
   end
endmodule // cssel_src_model

// ### verification/cssel_sva.sv
`timescale 1ns/1ps
module cssel_sva #(
   parameter int WDT_DIV      = 40,
   parameter int DLY_LONG_CYC = 65536
)(
   input wire logic                 core_clk_i,
   input wire logic                 reset_i,
   input wire logic                 hsel,
   input wire logic [31:0]          haddr,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic [31:0]          hwdata,
   input wire logic                 hready,
   input wire logic [31:0]          hrdata,
   input wire logic [3:0]           clock_source_select_fuses_i,
   input wire logic                 fuses_blank_i,
   input wire logic [7:0]           sigrow_data_i,
   input wire logic [7:0]           sigrow_addr_o,
   input wire cssel_pkg::cssel_cfg_t clk_cfg_o,
   input wire logic [7:0]           trim_value_o,
   input wire logic [7:0]           freq_min_pct_o,
   input wire logic [7:0]           freq_max_pct_o,
   input wire logic                 core_clk_en_o,
   input wire logic                 reset_hold_o,
   input wire logic                 wdog_tick_o
);
   import cssel_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   logic        wr_q;
   logic        rd_q;
   logic        seen_q;
   logic [15:0] gap_q;
   logic        hit;
   assign hit = hsel && htrans[1] && hready && haddr[11:0] == 12'h000;
   // first tick after reset is skipped: gap_q counts from reset there and reads WDT_DIV
   always_ff @(posedge core_clk_i)
   begin
      wr_q   <= !reset_i && hit && hwrite;
      rd_q   <= !reset_i && hit && !hwrite;
      seen_q <= !reset_i && (seen_q || wdog_tick_o);
      gap_q  <= (reset_i || wdog_tick_o) ? 16'h0000 : gap_q + 16'h0001;
   end
   a_reset_load: assert property (disable iff (1'b0) reset_i ##1 reset_i |->
      trim_value_o == $past(sigrow_data_i)) else $error("trim not loaded in reset");
   a_sig_addr: assert property (reset_hold_o |-> sigrow_addr_o == 8'h00)
      else $error("calibration address wrong");
   a_trim_write: assert property (wr_q |=> trim_value_o == $past(hwdata[7:0]))
      else $error("trim write lost");
   a_trim_read: assert property (rd_q |-> hrdata == {24'h000000, trim_value_o})
      else $error("trim read wrong");
   a_span_zero: assert property (trim_value_o == 8'h00 && $stable(trim_value_o) |->
      freq_min_pct_o == 8'h32 && freq_max_pct_o == 8'h64) else $error("span at zero");
   a_span_full: assert property (trim_value_o == 8'hff && $stable(trim_value_o) |->
      freq_min_pct_o == 8'h64 && freq_max_pct_o == 8'hc8) else $error("span at full");
   a_gate_hold: assert property (reset_hold_o |-> !core_clk_en_o)
      else $error("core clock open in reset hold");
   a_wdog_gap: assert property (seen_q && wdog_tick_o |-> gap_q == 16'(WDT_DIV - 1))
      else $error("watchdog tick spacing");
   a_cfg_int: assert property ($fell(reset_i) &&
      $past(clock_source_select_fuses_i) inside {[4'h1:4'h4]} |=> clk_cfg_o.src == SRC_INT_RC)
      else $error("internal source not chosen");
   a_cfg_erc: assert property ($fell(reset_i) && !$past(fuses_blank_i) &&
      $past(clock_source_select_fuses_i) inside {[4'h5:4'h8]} |=> clk_cfg_o.src == SRC_EXT_RC)
      else $error("external rc not chosen");
endmodule // cssel_sva
bind cssel_top cssel_sva #(.WDT_DIV(WDT_DIV), .DLY_LONG_CYC(DLY_LONG_CYC)) i_cssel_sva (
   .core_clk_i, .reset_i, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
   .clock_source_select_fuses_i, .fuses_blank_i, .sigrow_data_i, .sigrow_addr_o, .clk_cfg_o,
   .trim_value_o, .freq_min_pct_o, .freq_max_pct_o, .core_clk_en_o, .reset_hold_o, .wdog_tick_o
);

// ### verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import cssel_pkg::*;
   localparam int W = 3;
   localparam int P = 4;
   // trim points and their expected span, lowest byte first
   localparam logic [23:0] TRIM_PTS = 24'hff7f00;
   localparam logic [23:0] LO_PTS   = 24'h644b32;
   localparam logic [23:0] HI_PTS   = 24'hc89664;
   logic core_clk_i, reset_i, hsel, hwrite, hready, hreadyout, hresp, oscillator_option_fuse_i;
   logic fuses_blank_i, src_cycle_i, sleep_req_i, wake_i, core_clk_en_o, reset_hold_o;
   logic wdog_tick_o;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, startup_time_select_fuses_i;
   logic [2:0]  hsize;
   logic [3:0]  clock_source_select_fuses_i;
   logic [7:0]  sigrow_data_i, sigrow_addr_o, trim_value_o, freq_min_pct_o, freq_max_pct_o;
   cssel_cfg_t  clk_cfg_o;
   int          mismatches = 0;
   int          checks = 0;
   assign hready = hreadyout;
   cssel_top #(.WDT_DIV(W), .DLY_LONG_CYC(64)) i_cssel_top (
      .core_clk_i, .reset_i, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .clock_source_select_fuses_i, .startup_time_select_fuses_i,
      .oscillator_option_fuse_i, .fuses_blank_i, .sigrow_data_i, .src_cycle_i, .sleep_req_i,
      .wake_i, .sigrow_addr_o, .clk_cfg_o, .trim_value_o, .freq_min_pct_o, .freq_max_pct_o,
      .core_clk_en_o, .reset_hold_o, .wdog_tick_o);
   cssel_src_model #(.PER(P)) i_cssel_src_model (.core_clk_i, .src_cycle_o(src_cycle_i));
   initial
   begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task close_out;
   begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
   begin
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   end
   endtask
   // sel 0 waits for the core clock gate, sel 1 for bus ready
   task hold(input int sel, input int lim, output int c);
   begin
      c = 0;
      @(posedge core_clk_i);
      while ((sel == 0 ? core_clk_en_o : hreadyout) !== 1'b1)
      begin
         if (c >= lim)
         begin
            mismatches++;
            close_out();
         end
         c++;
         @(posedge core_clk_i);
      end
   end
   endtask
   task bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      int c;
   begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hold(1, 50, c);
      htrans <= 2'h0;
      hwdata <= d;
      hold(1, 50, c);
      r = hrdata;
   end
   endtask
   task su(input logic [3:0] ck, input logic [1:0] startup_time_select_fuses, input logic bl, input int d, n,
           input cssel_src_t s);
      int c;
      logic [31:0] r;
   begin
      @(posedge core_clk_i);
      reset_i <= 1'b1;
      clock_source_select_fuses_i <= ck;
      startup_time_select_fuses_i <= startup_time_select_fuses;
      fuses_blank_i <= bl;
      repeat (6) @(posedge core_clk_i);
      chk(reset_hold_o, 1'b1);
      chk(core_clk_en_o, 1'b0);
      reset_i <= 1'b0;
      hold(0, d * W + n * P + W + 8, c);
      chk(32'(c >= d * W + (n - 1) * P - W), 32'h1);
      chk(reset_hold_o, 1'b0);
      chk(sigrow_addr_o, 8'h00);
      chk(clk_cfg_o.src, s);
      chk(clk_cfg_o.fuse_err, (startup_time_select_fuses == 2'h3 && s != SRC_EXT_RC) || ck > 4'h8);
      chk(clk_cfg_o.oscillator_option_fuse_warn, 1'b0);
      if (s != SRC_EXT_CLK && !bl)
         chk(clk_cfg_o.range, 2'(ck - (s == SRC_EXT_RC ? 4'h5 : 4'h1)));
      chk(trim_value_o, 8'h5a);
      // software trim for 2, 4 and 8 MHz, kept well under nominal plus 10%
      if (s == SRC_INT_RC && ck >= 4'h2 && ck <= 4'h4)
      begin
         bus(32'h0, 1'b1, 32'h00000060, r);
         bus(32'h0, 1'b0, 32'h0, r);
         chk(r, 32'h00000060);
         chk(trim_value_o, 8'h60);
      end
      sleep_req_i <= 1'b1;
      @(posedge core_clk_i);
      sleep_req_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk(core_clk_en_o, 1'b0);
      wake_i <= 1'b1;
      @(posedge core_clk_i);
      wake_i <= 1'b0;
      hold(0, n * P + 8, c);
      chk(32'(c >= (n - 1) * P - 1), 32'h1);
   end
   endtask
   task regs;
      logic [31:0] r;
      logic [7:0]  v;
   begin
      for (int i = 0; i < 3; i++)
      begin
         v = TRIM_PTS[i * 8 +: 8];
         bus(32'h0, 1'b1, {24'h0, v}, r);
         bus(32'h0, 1'b0, 32'h0, r);
         chk(r, {24'h0, v});
         chk(freq_min_pct_o, LO_PTS[i * 8 +: 8]);
         chk(freq_max_pct_o, HI_PTS[i * 8 +: 8]);
      end
      bus(32'h4, 1'b0, 32'h0, r);
      chk(r[20:13], 8'hff);
      chk(hresp, 1'b0);
      bus(32'h8, 1'b1, 32'h1234, r);
      bus(32'h8, 1'b0, 32'h0, r);
      chk(r, 32'h0);
   end
   endtask
   initial
   begin
      reset_i = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      clock_source_select_fuses_i = 4'h1;
      startup_time_select_fuses_i = 2'h0;
      oscillator_option_fuse_i = 1'b0;
      fuses_blank_i = 1'b0;
      sigrow_data_i = 8'h5a;
      sleep_req_i = 1'b0;
      wake_i = 1'b0;
      su(4'h5, 2'h0, 1'b0, 0, 18, SRC_EXT_RC);
      su(4'h8, 2'h1, 1'b0, 4096, 18, SRC_EXT_RC);
      regs();
      su(4'h6, 2'h2, 1'b0, 64, 18, SRC_EXT_RC);
      su(4'h7, 2'h3, 1'b0, 4096, 6, SRC_EXT_RC);
      su(4'h1, 2'h0, 1'b0, 0, 6, SRC_INT_RC);
      su(4'h2, 2'h1, 1'b0, 4096, 6, SRC_INT_RC);
      su(4'h3, 2'h2, 1'b0, 64, 6, SRC_INT_RC);
      su(4'h4, 2'h3, 1'b0, 64, 6, SRC_INT_RC);
      su(4'h0, 2'h0, 1'b0, 0, 6, SRC_EXT_CLK);
      su(4'h0, 2'h2, 1'b0, 64, 6, SRC_EXT_CLK);
      su(4'h0, 2'h1, 1'b1, 64, 6, SRC_INT_RC);
      // a crystal code is not built here and falls back to the 1 MHz internal RC
      su(4'h9, 2'h0, 1'b0, 0, 6, SRC_INT_RC);
      close_out();
   end
endmodule // testbench
